/* File: hdl/mode_select_regs.svh */
// register offsets, field positions, reset values and timing for the mode-select bank
`ifndef MODE_SELECT_REGS_SVH
`define MODE_SELECT_REGS_SVH

`define OPMODE_SEL_ADDR      8'h03
`define BCMODE_SEL_ADDR      8'h04

`define OPMODE_RSVD7_BIT     7
`define OPMODE_STRAP6_BIT    6
`define OPMODE_RSVD5_BIT     5
`define OPMODE_OVERRIDE_BIT  4
`define OPMODE_LATCHED_BIT   3
`define OPMODE_FIELD_MSB     2

`define BCMODE_RSVD_MSB      7
`define BCMODE_RSVD_LSB      3
`define BCMODE_RAW10_BIT     2
`define BCMODE_RAW12_BIT     1
`define BCMODE_BLOCK_BIT     0

`define OPMODE_RESET         8'h00
`define BCMODE_RESET         8'h00

// strap settle time before the mode is considered latched
`define MODE_SETTLE_NS       200
`define CLK_PERIOD_NS        40
`define MODE_SETTLE_CYCLES   ((`MODE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hdl/mode_select_pkg.sv */
// types shared by the mode-select bank
package mode_select_pkg;

  typedef enum logic [2:0] {
    MODE_CSI_SYNC      = 3'h0,
    MODE_RESERVED      = 3'h1,
    MODE_CSI_NSYNC_EXT = 3'h2,
    MODE_CSI_NSYNC_AON = 3'h3,
    MODE_PV_EXT_CLK    = 3'h5
  } op_mode_t;

  typedef enum logic [1:0] {
    LATCH_IDLE   = 2'h0,
    LATCH_SETTLE = 2'h1,
    LATCH_DONE   = 2'h3
  } latch_state_t;

endpackage

/* File: hdl/mode_reg_if.sv */
// effective-mode and one-hot select carrier between the bank and its mode decoder
`timescale 1ns/1ns
`default_nettype none
interface mode_reg_if;
  logic [2:0] eff_mode;
  logic       sel_csi_sync;
  logic       sel_csi_nsync_ext;
  logic       sel_csi_nsync_aon;
  logic       sel_parallel_video;
  modport bank (output eff_mode, input sel_csi_sync, sel_csi_nsync_ext,
                sel_csi_nsync_aon, sel_parallel_video);
  modport dec (input eff_mode, output sel_csi_sync, sel_csi_nsync_ext,
               sel_csi_nsync_aon, sel_parallel_video);
endinterface
`default_nettype wire

/* File: hdl/mode_decoder.sv */
// decodes the effective mode into one-hot selects
`timescale 1ns/1ns
`default_nettype none
module mode_decoder
  import mode_select_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  mode_reg_if.dec   mif
);

  logic [3:0] sel;
  logic [3:0] next_sel;

  always_comb
  begin
    next_sel = 4'h0;
    unique case (op_mode_t'(mif.eff_mode))
      MODE_CSI_SYNC:      next_sel = 4'h1; // R6
      MODE_CSI_NSYNC_EXT: next_sel = 4'h2; // R6
      MODE_CSI_NSYNC_AON: next_sel = 4'h4; // R6
      MODE_PV_EXT_CLK:    next_sel = 4'h8; // R6
      default:            next_sel = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sel <= 4'h0;
    else
      sel <= next_sel;
  end

  assign mif.sel_csi_sync       = sel[0];
  assign mif.sel_csi_nsync_ext  = sel[1];
  assign mif.sel_csi_nsync_aon  = sel[2];
  assign mif.sel_parallel_video = sel[3];

  a_decode_pv : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    mif.eff_mode == 3'h5 |=> mif.sel_parallel_video) // R6
    else $error("parallel video mode not decoded");
  a_decode_sync : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    mif.eff_mode == 3'h0 |=> mif.sel_csi_sync && !mif.sel_parallel_video) // R6
    else $error("synchronous mode not decoded");

endmodule // mode_decoder
`default_nettype wire

/* File: hdl/serializer_mode_select.sv */
// mode-select and back-channel sub-mode register bank
`timescale 1ns/1ns
`default_nettype none
`include "mode_select_regs.svh"

// Overview of operation
// R1: with override clear the mode comes from the strap pin, with it set from the register field.
// R2: with override clear the mode field ignores writes and reads the mode in effect.
// R3: with override set the mode field takes writes and the value becomes the operating mode.
// R4: the strapped mode is captured on every low-to-high edge of the power-down input.
// R5: a read-only latched flag in bit 3 is 0 after reset and 1 once the mode has settled.
// R6: mode codes 000, 010, 011 and 101 select the four documented operating modes.
// R7: software must never write the reserved code 001 into the mode field.
// R8: receive lock loads the raw10 sub-mode bit unless auto-load is blocked.
// R9: receive lock loads the raw12 sub-mode bit unless auto-load is blocked.
// R10: software writing a sub-mode bit must also set the auto-load block bit.
// R11: while the block bit is set the control channel cannot change the sub-mode bits.
// R12: strap-derived fields take their reset value from the straps sampled at start-up; the code resets them to 0 and loads the straps after the settle.
// R13: the effective mode is a mux of register and latched strap and is what reads back.
module serializer_mode_select
  import mode_select_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] strap_mode_i,
  input  wire logic       strap_rsvd_i,
  input  wire logic       power_down_input_i,
  input  wire logic       rx_lock_i,
  input  wire logic       bc_raw10_i,
  input  wire logic       bc_raw12_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [2:0] op_mode_o,
  output logic            mode_latched_o,
  output logic            raw10_parallel_submode_o,
  output logic            raw12_parallel_submode_o,
  output logic            sel_csi_sync_o,
  output logic            sel_csi_nsync_ext_o,
  output logic            sel_csi_nsync_aon_o,
  output logic            sel_parallel_video_o
);

  localparam logic [3:0] SETTLE_CNT = 4'(`MODE_SETTLE_CYCLES);

  // pin synchronisers
  logic [2:0] strap_meta, strap_sync;
  logic       rsvd_meta, rsvd_sync;
  logic       pdn_meta, pdn_sync, pdn_prev;
  logic       lock_meta, lock_sync, lock_prev;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      rsvd_meta  <= 1'b0;
      rsvd_sync  <= 1'b0;
      pdn_meta   <= 1'b0;
      pdn_sync   <= 1'b0;
      pdn_prev   <= 1'b0;
      lock_meta  <= 1'b0;
      lock_sync  <= 1'b0;
      lock_prev  <= 1'b0;
    end
    else
    begin
      strap_meta <= strap_mode_i;
      strap_sync <= strap_meta;
      rsvd_meta  <= strap_rsvd_i;
      rsvd_sync  <= rsvd_meta;
      pdn_meta   <= power_down_input_i;
      pdn_sync   <= pdn_meta;
      pdn_prev   <= pdn_sync;
      lock_meta  <= rx_lock_i;
      lock_sync  <= lock_meta;
      lock_prev  <= lock_sync;
    end
  end

  logic pdn_rise;
  logic lock_rise;
  assign pdn_rise  = pdn_sync & ~pdn_prev;
  assign lock_rise = lock_sync & ~lock_prev;

  // register state
  logic         strap_override_select;
  logic [2:0]   reg_mode;
  logic [2:0]   strap_latched;
  logic         strap_rsvd;
  logic [1:0]   op_rsvd;
  logic         raw10_parallel_submode;
  logic         raw12_parallel_submode;
  logic         submode_autoload_block;
  logic [4:0]   bc_rsvd;
  latch_state_t latch_state;
  logic [3:0]   settle_cnt;

  logic         next_strap_override_select;
  logic [2:0]   next_reg_mode;
  logic [2:0]   next_strap_latched;
  logic         next_strap_rsvd;
  logic [1:0]   next_op_rsvd;
  logic         next_raw10_parallel_submode;
  logic         next_raw12_parallel_submode;
  logic         next_submode_autoload_block;
  logic [4:0]   next_bc_rsvd;
  latch_state_t next_latch_state;
  logic [3:0]   next_settle_cnt;
  logic [7:0]   next_rdata;

  logic [2:0]   eff_mode;
  logic         wr_op, wr_bc;
  assign wr_op = reg_wr_i && (reg_addr_i == `OPMODE_SEL_ADDR);
  assign wr_bc = reg_wr_i && (reg_addr_i == `BCMODE_SEL_ADDR);

  assign eff_mode = strap_override_select ? reg_mode : strap_latched; // R1 R13

  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `OPMODE_SEL_ADDR)
      val = {op_rsvd[1], strap_rsvd, op_rsvd[0], strap_override_select,
             latch_state == LATCH_DONE, eff_mode}; // R2 R5 R13
    else if (addr == `BCMODE_SEL_ADDR)
      val = {bc_rsvd, raw10_parallel_submode, raw12_parallel_submode,
             submode_autoload_block};
    return val;
  endfunction

  always_comb
  begin
    next_strap_override_select  = strap_override_select;
    next_reg_mode               = reg_mode;
    next_strap_latched          = strap_latched;
    next_strap_rsvd             = strap_rsvd;
    next_op_rsvd                = op_rsvd;
    next_raw10_parallel_submode = raw10_parallel_submode;
    next_raw12_parallel_submode = raw12_parallel_submode;
    next_submode_autoload_block = submode_autoload_block;
    next_bc_rsvd                = bc_rsvd;
    next_latch_state            = latch_state;
    next_settle_cnt             = settle_cnt;
    next_rdata                  = reg_rdata_o;

    // strap capture on power-down release, including the start-up one
    unique case (latch_state)
      LATCH_IDLE:
      begin
        if (pdn_rise)
        begin
          next_latch_state = LATCH_SETTLE;
          next_settle_cnt  = SETTLE_CNT;
        end
      end
      LATCH_SETTLE:
      begin
        if (!pdn_sync)
          next_latch_state = LATCH_IDLE;
        else if (settle_cnt == 4'h1)
        begin
          next_strap_latched = strap_sync; // R4 R12
          next_strap_rsvd    = rsvd_sync;  // R12
          next_latch_state   = LATCH_DONE; // R5
        end
        else
          next_settle_cnt = settle_cnt - 4'h1;
      end
      LATCH_DONE:
      begin
        if (!pdn_sync)
          next_latch_state = LATCH_IDLE; // R5
      end
      default: next_latch_state = LATCH_IDLE;
    endcase

    if (wr_op)
    begin
      next_strap_override_select = reg_wdata_i[`OPMODE_OVERRIDE_BIT];
      next_op_rsvd = {reg_wdata_i[`OPMODE_RSVD7_BIT], reg_wdata_i[`OPMODE_RSVD5_BIT]};
      if (strap_override_select || reg_wdata_i[`OPMODE_OVERRIDE_BIT])
        next_reg_mode = reg_wdata_i[`OPMODE_FIELD_MSB:0]; // R2 R3
    end

    // lock-driven auto-load, blocked while the block bit is set
    if (lock_rise && !submode_autoload_block)
    begin
      next_raw10_parallel_submode = bc_raw10_i; // R8 R11
      next_raw12_parallel_submode = bc_raw12_i; // R9 R11
    end

    if (wr_bc)
    begin
      next_bc_rsvd = reg_wdata_i[`BCMODE_RSVD_MSB:`BCMODE_RSVD_LSB];
      next_raw10_parallel_submode = reg_wdata_i[`BCMODE_RAW10_BIT];
      next_raw12_parallel_submode = reg_wdata_i[`BCMODE_RAW12_BIT];
      next_submode_autoload_block = reg_wdata_i[`BCMODE_BLOCK_BIT];
    end

    if (reg_rd_i)
      next_rdata = read_mux(reg_addr_i);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      strap_override_select  <= 1'b0; // R1
      reg_mode               <= 3'h0;
      strap_latched          <= 3'h0;
      strap_rsvd             <= 1'b0;
      op_rsvd                <= 2'h0;
      raw10_parallel_submode <= 1'b0;
      raw12_parallel_submode <= 1'b0;
      submode_autoload_block <= 1'b0; // R11
      bc_rsvd                <= 5'h00;
      latch_state            <= LATCH_IDLE;
      settle_cnt             <= 4'h0;
      reg_rdata_o            <= 8'h00;
    end
    else
    begin
      strap_override_select  <= next_strap_override_select;
      reg_mode               <= next_reg_mode;
      strap_latched          <= next_strap_latched;
      strap_rsvd             <= next_strap_rsvd;
      op_rsvd                <= next_op_rsvd;
      raw10_parallel_submode <= next_raw10_parallel_submode;
      raw12_parallel_submode <= next_raw12_parallel_submode;
      submode_autoload_block <= next_submode_autoload_block;
      bc_rsvd                <= next_bc_rsvd;
      latch_state            <= next_latch_state;
      settle_cnt             <= next_settle_cnt;
      reg_rdata_o            <= next_rdata;
    end
  end

  mode_reg_if mif ();
  assign mif.eff_mode = eff_mode;

  mode_decoder u_decoder (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .mif        (mif)
  );

  assign op_mode_o                = eff_mode;
  assign mode_latched_o           = (latch_state == LATCH_DONE);
  assign raw10_parallel_submode_o = raw10_parallel_submode;
  assign raw12_parallel_submode_o = raw12_parallel_submode;
  assign sel_csi_sync_o           = mif.sel_csi_sync;
  assign sel_csi_nsync_ext_o      = mif.sel_csi_nsync_ext;
  assign sel_csi_nsync_aon_o      = mif.sel_csi_nsync_aon;
  assign sel_parallel_video_o     = mif.sel_parallel_video;

  a_mode_from_strap : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !strap_override_select |-> op_mode_o == strap_latched) // R1
    else $error("mode not taken from strap");
  a_mode_write_ignored : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_op && !strap_override_select && !reg_wdata_i[4] |=> $stable(reg_mode)) // R2
    else $error("mode field took a write while not overridden");
  a_mode_write_taken : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_op && reg_wdata_i[4] |=> op_mode_o == $past(reg_wdata_i[2:0])) // R3
    else $error("override write did not set mode");
  a_strap_capture : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(mode_latched_o) |-> strap_latched == $past(strap_sync)) // R4
    else $error("strap not captured");
  a_latched_settle : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    pdn_rise |-> !mode_latched_o [*5]) // R5
    else $error("latched flag set before settle time");
  a_autoload_lock : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    lock_rise && !submode_autoload_block && !wr_bc
      |=> raw10_parallel_submode == $past(bc_raw10_i)
       && raw12_parallel_submode == $past(bc_raw12_i)) // R8
    else $error("sub-mode not loaded on lock");
  a_autoload_block : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    submode_autoload_block && !wr_bc
      |=> $stable(raw10_parallel_submode) && $stable(raw12_parallel_submode)) // R11
    else $error("sub-mode changed while blocked");
  a_readback_eff : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o[2:0] == $past(op_mode_o)) // R13
    else $error("mode readback differs from effective mode");

endmodule // serializer_mode_select
`default_nettype wire

/* File: test/bc_link_model.sv */
// far side of the control channel: receive lock and sub-mode delivery
`timescale 1ns/1ns
`default_nettype none
module bc_link_model (
  input  wire logic core_clk_i,
  output logic      rx_lock_o,
  output logic      bc_raw10_o,
  output logic      bc_raw12_o
);
  initial
  begin
    rx_lock_o  = 1'b0;
    bc_raw10_o = 1'b1;
    bc_raw12_o = 1'b0;
  end

  // values are presented with the lock rise and held for the whole lock period
  task automatic link_up(input logic r10, input logic r12);
    @(negedge core_clk_i);
    bc_raw10_o = r10;
    bc_raw12_o = r12;
    rx_lock_o  = 1'b1;
  endtask

  // once lock is lost the lines no longer carry the delivered values
  task automatic link_down();
    @(negedge core_clk_i);
    rx_lock_o  = 1'b0;
    bc_raw10_o = ~bc_raw10_o;
    bc_raw12_o = ~bc_raw12_o;
  endtask
endmodule // bc_link_model
`default_nettype wire

/* File: test/serializer_mode_select_tb.sv */
// self-checking bench for the mode-select register bank
`timescale 1ns/1ns
`default_nettype none
`include "mode_select_regs.svh"
`define CHK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module serializer_mode_select_tb;
  import mode_select_pkg::*;
  logic       core_clk_i, rstn_i, strap_rsvd_i, power_down_input_i, reg_wr_i, reg_rd_i;
  logic [2:0] strap_mode_i, op_mode_o, m;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic       rx_lock, bc_raw10, bc_raw12, mode_latched_o, raw10_o, raw12_o, r;
  wire  [3:0] sel;
  logic [1:0] sub;
  int         errors, checked, i;
  // the four documented codes used by the strap and override loops; the reserved one is never programmed
  logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};

  serializer_mode_select dut (
    .core_clk_i               (core_clk_i),
    .rstn_i                   (rstn_i),
    .strap_mode_i             (strap_mode_i),
    .strap_rsvd_i             (strap_rsvd_i),
    .power_down_input_i       (power_down_input_i),
    .rx_lock_i                (rx_lock),
    .bc_raw10_i               (bc_raw10),
    .bc_raw12_i               (bc_raw12),
    .reg_wr_i                 (reg_wr_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_rdata_o              (reg_rdata_o),
    .op_mode_o                (op_mode_o),
    .mode_latched_o           (mode_latched_o),
    .raw10_parallel_submode_o (raw10_o),
    .raw12_parallel_submode_o (raw12_o),
    .sel_csi_sync_o           (sel[3]),
    .sel_csi_nsync_ext_o      (sel[2]),
    .sel_csi_nsync_aon_o      (sel[1]),
    .sel_parallel_video_o     (sel[0])
  );

  bc_link_model partner (
    .core_clk_i (core_clk_i),
    .rx_lock_o  (rx_lock),
    .bc_raw10_o (bc_raw10),
    .bc_raw12_o (bc_raw12)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  function automatic logic [3:0] sel_exp(input logic [2:0] md);
    return {md == 3'h0, md == 3'h2, md == 3'h3, md == 3'h5};
  endfunction

  function automatic logic [7:0] mode_reg(input logic rs, input logic ov, input logic [2:0] md);
    return {1'b0, rs, 1'b0, ov, 1'b1, md};
  endfunction

  task automatic conclude();
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    @(negedge core_clk_i);
    `CHK(reg_rdata_o, e)
  endtask

  task automatic wait_latched(input logic v);
    int n;
    for (n = 0; n < 30 && mode_latched_o !== v; n++)
      @(negedge core_clk_i);
    if (n == 30)
    begin
      errors++;
      conclude();
    end
  endtask

  task automatic power_cycle(input logic [2:0] md, input logic rs);
    power_down_input_i = 1'b0;
    strap_mode_i       = md;
    strap_rsvd_i       = rs;
    wait_latched(1'b0);
    repeat (4) @(negedge core_clk_i);
    power_down_input_i = 1'b1;
    wait_latched(1'b1);
    @(negedge core_clk_i);
  endtask

  // blocked loads are given the full window to show that nothing changes
  task automatic wait_sub(input logic [1:0] e, input bit blk);
    int n;
    for (n = 0; n < 12 && (blk || {raw10_o, raw12_o} !== e); n++)
      @(negedge core_clk_i);
    if (n == 12 && !blk)
    begin
      errors++;
      conclude();
    end
    `CHK({raw10_o, raw12_o}, e)
  endtask

  initial
  begin
    rstn_i = 1'b0;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {power_down_input_i, strap_mode_i, strap_rsvd_i} = '0;
    errors  = 0;
    checked = 0;
    void'($urandom(75631));
    repeat (12) @(negedge core_clk_i);
    rstn_i = 1'b1;
    `CHK(mode_latched_o, 1'b0)
    rd_chk(`OPMODE_SEL_ADDR, `OPMODE_RESET);
    rd_chk(`BCMODE_SEL_ADDR, `BCMODE_RESET);
    for (i = 0; i < 6; i++)
    begin
      m = modes[$urandom_range(3)];
      r = 1'($urandom_range(1));
      power_cycle(m, r);
      `CHK(op_mode_o, m)
      `CHK(sel, sel_exp(m))
      wr(`OPMODE_SEL_ADDR, {5'h00, (m == 3'h3) ? 3'h5 : 3'h3});
      `CHK(op_mode_o, m)
      rd_chk(`OPMODE_SEL_ADDR, mode_reg(r, 1'b0, m));
    end
    for (i = 0; i < 4; i++)
    begin
      wr(`OPMODE_SEL_ADDR, 8'h10 | {5'h00, modes[i]});
      `CHK(op_mode_o, modes[i])
      `CHK(sel, sel_exp(modes[i]))
      rd_chk(`OPMODE_SEL_ADDR, mode_reg(r, 1'b1, modes[i]));
    end
    // a code outside the documented four selects nothing
    wr(`OPMODE_SEL_ADDR, 8'h14);
    `CHK(op_mode_o, 3'h4)
    `CHK(sel, sel_exp(3'h4))
    power_cycle(3'h2, r);
    `CHK(op_mode_o, 3'h4)
    // reserved bits 7 and 5 keep what is written, bits 6 and 3 do not
    wr(`OPMODE_SEL_ADDR, 8'hE8);
    `CHK(op_mode_o, 3'h2)
    rd_chk(`OPMODE_SEL_ADDR, mode_reg(r, 1'b0, 3'h2) | 8'hA0);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      // every delivery differs from what the bits already hold
      sub = 2'(i + 1);
      partner.link_up(sub[1], sub[0]);
      wait_sub(sub, 1'b0);
      rd_chk(`BCMODE_SEL_ADDR, {5'h00, sub, 1'b0});
      partner.link_down();
      repeat (4) @(negedge core_clk_i);
    end
    wr(`BCMODE_SEL_ADDR, 8'hF9);
    rd_chk(`BCMODE_SEL_ADDR, 8'hF9);
    wr(`BCMODE_SEL_ADDR, 8'h01);
    partner.link_up(1'b1, 1'b1);
    wait_sub(2'h0, 1'b1);
    rd_chk(`BCMODE_SEL_ADDR, 8'h01);
    partner.link_down();
    wr(`BCMODE_SEL_ADDR, 8'h00);
    repeat (4) @(negedge core_clk_i);
    partner.link_up(1'b1, 1'b0);
    wait_sub(2'h2, 1'b0);
    // mid-run reset with power-down and lock both high: straps and sub-modes come back
    rstn_i = 1'b0;
    @(negedge core_clk_i);
    rstn_i = 1'b1;
    `CHK({raw10_o, raw12_o, mode_latched_o}, 3'h0)
    rd_chk(`OPMODE_SEL_ADDR, `OPMODE_RESET);
    wait_latched(1'b1);
    rd_chk(`OPMODE_SEL_ADDR, mode_reg(r, 1'b0, 3'h2));
    wait_sub(2'h2, 1'b0);
    conclude();
  end
endmodule // serializer_mode_select_tb
`default_nettype wire
